// ===== rtl/uarf_defines.vh
// register offsets, field positions, reset values and encodings of the receive address filter
`ifndef UARF_DEFINES_VH
`define UARF_DEFINES_VH

`define UARF_ADDR_W 4
`define UARF_OFS_CTRL 4'h0
`define UARF_OFS_SLAVE_ADDRESS 4'h1
`define UARF_OFS_SMASK 4'h2
`define UARF_OFS_BUF 4'h3
`define UARF_OFS_STAT 4'h4
`define UARF_OFS_BCAST 4'h5

`define UARF_CTRL_MODE_LSB 0
`define UARF_CTRL_MODE_MSB 1
`define UARF_CTRL_MPE_BIT 2

`define UARF_STAT_RXC_BIT 0
`define UARF_STAT_NINTH_BIT 1

`define UARF_MODE_SHIFT 2'h0
`define UARF_MODE_ASYNC8 2'h1
`define UARF_MODE_NINE_FIX 2'h2
`define UARF_MODE_NINE_VAR 2'h3

`define UARF_CTRL_RST 8'h00
`define UARF_SLAVE_ADDRESS_RST 8'h00
`define UARF_SMASK_RST 8'h00
`define UARF_BUF_RST 8'h00

`endif

// ===== rtl/uarf_rx_address_filter.v
// receive-side multiprocessor address filter of a serial port
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "uarf_defines.vh"

module uarf_rx_address_filter (
	input wire clk_i, // 250 MHz clock
	input wire nrst_i, // asynchronous reset, active low
	input wire [3:0] addr_i, // register address
	input wire [7:0] wdata_i, // register write data
	input wire wr_i, // write strobe
	input wire rd_i, // read strobe
	output reg [7:0] rdata_o, // read data, one cycle after rd_i
	input wire frame_valid_i, // one-cycle pulse: frame shifter finished a frame
	input wire [7:0] frame_data_i, // eight data bits of the frame
	input wire frame_bit9_i, // ninth bit in modes 2/3, stop bit in mode 1
	output reg [1:0] mode_o, // serial mode for the frame shifter
	output reg [7:0] serial_buffer_o, // received byte
	output reg rx_ninth_bit_o, // received ninth bit
	output reg rx_complete_flag_o, // receive-complete flag
	output reg rx_load_o // one-cycle pulse: a frame was accepted
);

	reg multiproc_enable_q;
	reg [7:0] slave_address_q;
	reg [7:0] slave_address_mask_q;
	wire given_match;
	wire bcast_match;
	wire [7:0] bcast_addr;
	reg accept;
	wire clr_flag;
	wire write_stat;

	assign given_match = ((frame_data_i ^ slave_address_q) & slave_address_mask_q) == 8'h00;
	assign bcast_addr = slave_address_q | slave_address_mask_q;
	assign bcast_match = ((frame_data_i ^ 8'hff) & bcast_addr) == 8'h00;
	assign write_stat = wr_i && (addr_i == `UARF_OFS_STAT);
	assign clr_flag = write_stat && !wdata_i[`UARF_STAT_RXC_BIT];

	// decide whether the finished frame may be loaded
	always @* begin
		accept = 1'b0;
		if (frame_valid_i && !rx_complete_flag_o) begin
			if (!multiproc_enable_q || mode_o == `UARF_MODE_SHIFT) begin
				accept = 1'b1;
			end else if (mode_o == `UARF_MODE_ASYNC8) begin
				accept = frame_bit9_i;
			end else begin
				// data frames dropped; address frames must hit given or broadcast
				accept = frame_bit9_i && (given_match || bcast_match);
			end
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_o <= `UARF_MODE_SHIFT;
			multiproc_enable_q <= 1'b0;
			slave_address_q <= `UARF_SLAVE_ADDRESS_RST;
			slave_address_mask_q <= `UARF_SMASK_RST;
		end else if (wr_i) begin
			case (addr_i)
				`UARF_OFS_CTRL: begin
					mode_o <= wdata_i[`UARF_CTRL_MODE_MSB:`UARF_CTRL_MODE_LSB];
					multiproc_enable_q <= wdata_i[`UARF_CTRL_MPE_BIT];
				end
				`UARF_OFS_SLAVE_ADDRESS: begin
					slave_address_q <= wdata_i;
				end
				`UARF_OFS_SMASK: begin
					slave_address_mask_q <= wdata_i;
				end
				default: begin
				end
			endcase
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			serial_buffer_o <= `UARF_BUF_RST;
			rx_ninth_bit_o <= 1'b0;
			rx_complete_flag_o <= 1'b0;
			rx_load_o <= 1'b0;
		end else begin
			rx_load_o <= accept;
			if (accept) begin
				serial_buffer_o <= frame_data_i;
				// mode 0 has no ninth bit; modes 1-3 keep stop or ninth bit
				rx_ninth_bit_o <= (mode_o == `UARF_MODE_SHIFT) ? rx_ninth_bit_o : frame_bit9_i;
				rx_complete_flag_o <= 1'b1;
			end else begin
				// an accepted frame wins over a clear in the same cycle
				if (clr_flag) begin
					rx_complete_flag_o <= 1'b0;
				end
			end
		end
	end

	// read port: data stand one cycle after the strobe
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				`UARF_OFS_CTRL: rdata_o <= {5'h00, multiproc_enable_q, mode_o};
				`UARF_OFS_SLAVE_ADDRESS: rdata_o <= slave_address_q;
				`UARF_OFS_SMASK: rdata_o <= slave_address_mask_q;
				`UARF_OFS_BUF: rdata_o <= serial_buffer_o;
				`UARF_OFS_STAT: rdata_o <= {6'h00, rx_ninth_bit_o, rx_complete_flag_o};
				`UARF_OFS_BCAST: rdata_o <= bcast_addr;
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

endmodule

// ===== testbench/uarf_checker.sv
// concurrent checks on the filter ports
`timescale 1ns/1ns
module uarf_checker(input wire clk_i, nrst_i, wr_i, rd_i, frame_valid_i, frame_bit9_i, rx_ninth_bit_o,
	rx_complete_flag_o, rx_load_o, input wire [3:0] addr_i, input wire [1:0] mode_o,
	input wire [7:0] wdata_i, rdata_o, frame_data_i, serial_buffer_o);
	logic m_q;
	logic [7:0] a_q, k_q;
	wire [7:0] d = frame_data_i;
	wire fv = frame_valid_i & !rx_complete_flag_o;
	// given or broadcast match on an address frame, stop bit set in mode 1, or no filtering at all
	wire hit = !m_q || mode_o == 2'h0 || frame_bit9_i && (mode_o == 2'h1 || ((d ^ a_q) & k_q) == 8'h0
		|| &(d | ~(a_q | k_q)));
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) {m_q, a_q, k_q} <= 17'h0;
		else if (wr_i && addr_i == 4'h0) m_q <= wdata_i[2];
		else if (wr_i && addr_i == 4'h1) a_q <= wdata_i;
		else if (wr_i && addr_i == 4'h2) k_q <= wdata_i;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	accept_a: assert property (fv && hit |=> rx_load_o) else $error("lost");
	refuse_a: assert property (frame_valid_i && !hit |=> !rx_load_o) else $error("taken");
	full_drop_a: assert property (rx_load_o |-> $past(fv)) else $error("full");
	buf_load_a: assert property (rx_load_o |-> rx_complete_flag_o && serial_buffer_o == $past(d))
		else $error("byte");
	ninth_load_a: assert property (rx_load_o && mode_o != 2'h0 |-> rx_ninth_bit_o == $past(frame_bit9_i))
		else $error("ninth");
	buf_hold_a: assert property (!rx_load_o |-> $stable(serial_buffer_o) && $stable(rx_ninth_bit_o))
		else $error("moved");
	bcast_read_a: assert property (rd_i && addr_i == 4'h5 |=> rdata_o == (a_q | k_q)) else $error("bcast");
	shift_mode_a: assert property (fv && mode_o == 2'h0 |=> rx_load_o) else $error("mode0");
	cover property (rx_load_o && mode_o == 2'h1);
	cover property (frame_valid_i && rx_complete_flag_o);
	cover property (rx_load_o && mode_o == 2'h3);
endmodule
bind uarf_rx_address_filter uarf_checker chk_u(.*);

// ===== testbench/uarf_node.sv
// far node: hands each frame over as a one-cycle pulse
`timescale 1ns/1ns
module uarf_node(input wire clk_i, go_i, input wire [8:0] w_i, output logic v_o = 1'b0,
	output logic [8:0] f_o = 9'h000);
	always @(posedge clk_i) v_o <= go_i;
	always @(posedge clk_i) f_o <= go_i ? w_i : ~f_o;
endmodule

// ===== testbench/uarf_rx_address_filter_test.sv
// self-checking bench of the receive address filter
`timescale 1ns/1ns
module uarf_rx_address_filter_test;
	logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, go = 0, rx_ninth_bit_o, rx_complete_flag_o, rx_load_o;
	logic [3:0] addr_i = 0;
	logic [7:0] wdata_i = 0, rdata_o, serial_buffer_o;
	logic [8:0] w = 0;
	logic [1:0] mode_o;
	wire frame_valid_i, frame_bit9_i;
	wire [7:0] frame_data_i;
	int failures = 0, n_checks = 0, cyc = 0;
	// op 1 write, 2 read, 4 frame dropped, c frame taken
	logic [15:0] t[29] = '{16'h2500, 16'h1006, 16'hc1a5, 16'h2403, 16'h41c4, 16'h23a5, 16'h1400, 16'h40a5,
		16'h11c0, 16'h12fd, 16'h25fd, 16'h41c1, 16'hc1c2, 16'h1400, 16'h1007, 16'hc1fd, 16'h1400, 16'h1005,
		16'h4033, 16'hc133, 16'h1400, 16'h1004, 16'hc055, 16'h1400, 16'h1002, 16'hc066, 16'h1377, 16'h2366,
		16'h2f00};
	uarf_rx_address_filter dut_u(.*);
	uarf_node node_u(.clk_i(clk_i), .go_i(go), .w_i(w), .v_o(frame_valid_i), .f_o({frame_bit9_i, frame_data_i}));
	initial forever #2 clk_i = ~clk_i;
	always @(posedge clk_i) if (++cyc == 2000) begin
		failures++;
		final_report;
	end
	task final_report;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [7:0] s, e);
		n_checks++;
		if (s !== e) $display("wrong value at %0t: %h not %h", $time, s, e);
		if (s !== e) failures++;
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		nrst_i <= 1;
		foreach (t[i]) begin
			@(posedge clk_i) {wr_i, rd_i, go, addr_i, wdata_i, w} <= {t[i][12], t[i][13], t[i][14], t[i][11:0], t[i][8:0]};
			@(posedge clk_i) {wr_i, rd_i, go} <= 3'h0;
			#1 if (t[i][13]) chk(rdata_o, t[i][7:0]);
			@(posedge clk_i) #1 if (t[i][14]) chk(rx_load_o, t[i][15]);
			if (t[i][15]) chk(serial_buffer_o, t[i][7:0]);
		end
		chk({6'h00, mode_o}, 8'h02);
		chk({7'h00, rx_complete_flag_o}, 8'h01);
		chk({7'h00, rx_ninth_bit_o}, 8'h00);
		final_report;
	end
endmodule
